// >>> src/pig_pkg.sv
// Constants and types for the port input gating register bank
package pig_pkg;
    localparam int PIG_NUM_PORTS = 3;
    localparam int PIG_PORT_WIDTH = 8;
    localparam int PIG_ADR_WIDTH = 16;
    localparam int PIG_DAT_WIDTH = 32;
    localparam int PIG_SEL_WIDTH = 4;
    localparam int PIG_IDX_WIDTH = 14;
    localparam int PIG_IDX_LSB = 2;

    // Register indices; byte address is four times the index
    localparam logic [13:0] PIG_IDX_PORT_B = 14'h30B9;
    localparam logic [13:0] PIG_IDX_PORT_C = 14'h30BA;
    localparam logic [13:0] PIG_IDX_PORT_D = 14'h30BB;

    localparam int PIG_PORT_B = 0;
    localparam int PIG_PORT_C = 1;
    localparam int PIG_PORT_D = 2;

    localparam logic [7:0] PIG_GATE_RESET = 8'h00;
    localparam logic [7:0] PIG_GATED_OFF = 8'h00;
    localparam logic [31:0] PIG_DAT_ZERO = 32'h0000_0000;
    localparam logic [23:0] PIG_DAT_PAD = 24'h00_0000;
    localparam int PIG_LANE_LOW = 0;

    typedef logic [PIG_PORT_WIDTH-1:0] pig_byte_t;
    typedef pig_byte_t [PIG_NUM_PORTS-1:0] pig_bank_t;

    // Classic Wishbone request bundle from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [PIG_ADR_WIDTH-1:0] adr;
        logic [PIG_SEL_WIDTH-1:0] sel;
        logic [PIG_DAT_WIDTH-1:0] dat;
    } pig_wb_req_t;
endpackage : pig_pkg

// >>> src/pig_input_gate_bank.sv
// Port B/C/D input gating registers behind a classic Wishbone slave
//
// Behaviour
// - Port B gating register at index 30B9h, bit n gates pin n.
// - Port C gating register at index 30BAh, bit n gates pin n.
// - Port D gating register at index 30BBh, bit n gates pin n.
// - A gating bit of 0 blocks that pin level from the input logic.
// - A gating bit of 1 passes that pin level to the input logic.
// - All eight bits of each register write freely and read back.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
module pig_input_gate_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire pig_pkg::pig_wb_req_t wb_req_i,
    output logic [pig_pkg::PIG_DAT_WIDTH-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Pin side
    input wire pig_pkg::pig_bank_t pin_level_i,
    output pig_pkg::pig_bank_t input_gate_o,
    output pig_pkg::pig_bank_t gated_level_o
);
    import pig_pkg::*;

    // Bus handshake: one answer per request, then back to idle
    typedef enum logic {
        PIG_BUS_IDLE,
        PIG_BUS_ACK
    } pig_bus_state_t;

    // Request decode
    logic req;
    logic accept;
    logic lane_low;
    logic write_cycle;
    logic [PIG_IDX_WIDTH-1:0] idx;
    logic [PIG_PORT_WIDTH-1:0] wdat;
    wire [PIG_IDX_WIDTH-1:0] port_idx [PIG_NUM_PORTS];
    wire [PIG_NUM_PORTS-1:0] hit;
    wire [PIG_NUM_PORTS-1:0] wr_port;

    // Bus handshake state
    pig_bus_state_t bus_state;
    pig_bus_state_t next_bus_state;
    logic ack;
    logic next_ack;

    // Read data path
    pig_byte_t rd_byte;
    logic [PIG_DAT_WIDTH-1:0] rdat;
    logic [PIG_DAT_WIDTH-1:0] next_rdat;

    // Gating registers and gated levels, gathered from the per-pin cells
    wire pig_bank_t gate;
    wire pig_bank_t gated;

    // Byte address to word index; the lane bits below it are ignored
    assign idx = wb_req_i.adr[PIG_ADR_WIDTH-1:PIG_IDX_LSB];
    assign req = wb_req_i.cyc & wb_req_i.stb;
    assign accept = req & (bus_state == PIG_BUS_IDLE);
    assign lane_low = wb_req_i.sel[PIG_LANE_LOW];
    assign wdat = wb_req_i.dat[PIG_PORT_WIDTH-1:0];
    // Write lands on the edge where the master sees ack, not a cycle early
    assign write_cycle = req & ack & wb_req_i.we & lane_low;

    assign port_idx[PIG_PORT_B] = PIG_IDX_PORT_B;
    assign port_idx[PIG_PORT_C] = PIG_IDX_PORT_C;
    assign port_idx[PIG_PORT_D] = PIG_IDX_PORT_D;

    // Per-port decode and per-pin storage
    genvar p;
    genvar b;
    generate
        for (p = 0; p < PIG_NUM_PORTS; p++) begin : g_port
            assign hit[p] = (idx == port_idx[p]);
            assign wr_port[p] = write_cycle & hit[p];

            for (b = 0; b < PIG_PORT_WIDTH; b++) begin : g_pin
                logic gate_bit;
                logic next_gate_bit;
                logic gated_bit;
                logic next_gated_bit;

                // Gate bit: reset, software write through lane 0, or hold
                always_comb begin
                    if (rst_i) begin
                        next_gate_bit = PIG_GATE_RESET[b];
                    end else if (wr_port[p]) begin
                        next_gate_bit = wdat[b];
                    end else begin
                        next_gate_bit = gate_bit;
                    end
                end

                always_ff @(posedge clk_i) begin
                    gate_bit <= next_gate_bit;
                end

                // Disabled pins read low so a floating input never leaks through
                always_comb begin
                    if (rst_i) begin
                        next_gated_bit = PIG_GATED_OFF[b];
                    end else if (gate_bit) begin
                        next_gated_bit = pin_level_i[p][b];
                    end else begin
                        next_gated_bit = PIG_GATED_OFF[b];
                    end
                end

                always_ff @(posedge clk_i) begin
                    gated_bit <= next_gated_bit;
                end

                assign gate[p][b] = gate_bit;
                assign gated[p][b] = gated_bit;
            end
        end
    endgenerate

    // Read select; unmapped words read as zero
    always_comb begin
        if (hit[PIG_PORT_B]) begin
            rd_byte = gate[PIG_PORT_B];
        end else if (hit[PIG_PORT_C]) begin
            rd_byte = gate[PIG_PORT_C];
        end else if (hit[PIG_PORT_D]) begin
            rd_byte = gate[PIG_PORT_D];
        end else begin
            rd_byte = PIG_DAT_ZERO[PIG_PORT_WIDTH-1:0];
        end
    end

    // A held request is answered every other cycle, never twice in a row
    always_comb begin
        if (rst_i) begin
            next_bus_state = PIG_BUS_IDLE;
            next_ack = 1'b0;
        end else begin
            case (bus_state)
                PIG_BUS_IDLE: begin
                    if (req) begin
                        next_bus_state = PIG_BUS_ACK;
                        next_ack = 1'b1;
                    end else begin
                        next_bus_state = PIG_BUS_IDLE;
                        next_ack = 1'b0;
                    end
                end
                PIG_BUS_ACK: begin
                    next_bus_state = PIG_BUS_IDLE;
                    next_ack = 1'b0;
                end
                default: begin
                    next_bus_state = PIG_BUS_IDLE;
                    next_ack = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        bus_state <= next_bus_state;
        ack <= next_ack;
    end

    // Read data stands only in the ack cycle and is zero otherwise
    always_comb begin
        if (rst_i) begin
            next_rdat = PIG_DAT_ZERO;
        end else if (accept) begin
            next_rdat = {PIG_DAT_PAD, rd_byte};
        end else begin
            next_rdat = PIG_DAT_ZERO;
        end
    end

    always_ff @(posedge clk_i) begin
        rdat <= next_rdat;
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign input_gate_o = gate;
    assign gated_level_o = gated;
endmodule : pig_input_gate_bank

// >>> tb/pig_props.sv
// Bus, register and gating checks for the input gate bank
`timescale 1ns/1ps
module pig_props import pig_pkg::*; (
    input wire logic clk_i, rst_i, wb_ack_o,
    input wire pig_wb_req_t wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire pig_bank_t pin_level_i, input_gate_o, gated_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rq = wb_req_i.cyc & wb_req_i.stb;
    wire wr = wb_ack_o & rq & wb_req_i.we & wb_req_i.sel[0];
    wire [13:0] ix = wb_req_i.adr[15:2];
    wire [7:0] wd = wb_req_i.dat[7:0];
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_next: assert property (rq && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_wr_b: assert property (wr && ix == PIG_IDX_PORT_B |=> input_gate_o[0] == $past(wd))
        else $error("port B write lost");
    a_wr_c: assert property (wr && ix == PIG_IDX_PORT_C |=> input_gate_o[1] == $past(wd))
        else $error("port C write lost");
    a_wr_d: assert property (wr && ix == PIG_IDX_PORT_D |=> input_gate_o[2] == $past(wd))
        else $error("port D write lost");
    a_rd_back: assert property (wb_ack_o && rq && !wb_req_i.we && ix == PIG_IDX_PORT_D
        |-> wb_dat_o == {24'h000000, input_gate_o[2]}) else $error("read mismatch");
    a_gate_pass: assert property (gated_level_o == $past(pin_level_i & input_gate_o))
        else $error("gated level wrong");
    a_rst_clear: assert property (disable iff (1'b0) rst_i |=> input_gate_o == '0)
        else $error("gate not cleared");
    c_write: cover property (wr);
    c_read: cover property (wb_ack_o && !wb_req_i.we);
    c_pass: cover property (|gated_level_o);
endmodule : pig_props
bind pig_input_gate_bank pig_props u_props (.clk_i, .rst_i, .wb_ack_o, .wb_req_i, .wb_dat_o,
    .pin_level_i, .input_gate_o, .gated_level_o);

// >>> tb/tb.sv
// Self-checking bench for the input gate bank
`timescale 1ns/1ps
module tb;
    import pig_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_ack_o;
    logic [31:0] dat, r;
    pig_wb_req_t rq = '0;
    logic [3:0] sel = 4'hF;
    pig_bank_t pins = '0, gate, lvl;
    int num_errors = 0, checked = 0;
    always #4 clk_i = ~clk_i;
    pig_input_gate_bank dut (.clk_i, .rst_i, .wb_req_i(rq), .wb_dat_o(dat), .wb_ack_o,
        .pin_level_i(pins), .input_gate_o(gate), .gated_level_o(lvl));
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Idle edge after each cycle keeps cyc low between requests
    task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        rq <= '{1'b1, 1'b1, w, a, sel, {24'h000000, d}};
        // Only the watchdog ends a wait for an answer that never comes
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        r = dat;
        rq <= '0;
        @(posedge clk_i);
    endtask : bus
    task t_regs;
        for (int p = 0; p < 3; p++) begin
            bus(1'b0, 16'hC2E4 + 16'(4 * p), 8'h00);
            chk(r, 32'h0);
            bus(1'b1, 16'hC2E4 + 16'(4 * p), 8'h5A ^ 8'(p));
            bus(1'b0, 16'hC2E4 + 16'(4 * p), 8'h00);
            chk(r, {24'h000000, 8'h5A ^ 8'(p)});
        end
        // Unmapped write must leave every gate alone
        bus(1'b1, 16'hC2F0, 8'hFF);
        chk(32'(gate), 32'h585B5A);
    endtask : t_regs
    // Write without the low byte lane must leave the gate alone
    task t_lane;
        sel = 4'hE;
        bus(1'b1, 16'hC2E4, 8'h00);
        sel = 4'hF;
        chk(32'(gate[0]), 32'h5A);
    endtask : t_lane
    task t_gate;
        bus(1'b1, 16'hC2E4, 8'hFF);
        bus(1'b1, 16'hC2E8, 8'h00);
        bus(1'b1, 16'hC2EC, 8'h0F);
        pins <= {8'h3C, 8'hA5, 8'h96};
        repeat (2) @(posedge clk_i);
        chk(32'(lvl), 32'h0C0096);
    endtask : t_gate
    task print_verdict;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        num_errors++;
        print_verdict;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_lane;
        t_gate;
        print_verdict;
    end
endmodule : tb
